// [logic/afic_consts.vh]
// shared constants for the flush and identify command block
`ifndef AFIC_CONSTS_VH
`define AFIC_CONSTS_VH

// register port addresses
`define AFIC_A_DATA 4'h0
`define AFIC_A_ERR 4'h1
`define AFIC_A_COUNT 4'h2
`define AFIC_A_LBA_LO 4'h3
`define AFIC_A_LBA_MID 4'h4
`define AFIC_A_LBA_HI 4'h5
`define AFIC_A_DEVICE 4'h6
`define AFIC_A_STATUS 4'h7
`define AFIC_A_CTRL 4'h8
`define AFIC_A_CONFIG 4'h9
`define AFIC_A_MULTI 4'hA

// opcodes
`define AFIC_OP_FLUSH 8'hE7
`define AFIC_OP_FLUSH_EXT 8'hEA
`define AFIC_OP_IDENT 8'hEC

// status values: bsy=7 rdy=6 dsc=4 drq=3 err=0
`define AFIC_ST_READY 8'h50
`define AFIC_ST_BUSY 8'h80
`define AFIC_ST_DRQ 8'h58
`define AFIC_ST_ABORT 8'h51
`define AFIC_ST_BSY_BIT 7
`define AFIC_ERR_ABRT 8'h04
`define AFIC_CTRL_HOB 7

// configuration register
`define AFIC_CFG_RST 8'h01
`define AFIC_CFG_FLUSH_EN 0

// identify block
`define AFIC_ID_LAST 8'hFF
`define AFIC_W0 16'h0040
`define AFIC_W1 16'h3FFF
`define AFIC_W2 16'hC837
`define AFIC_W3 16'h0010
`define AFIC_W5 16'h0240
`define AFIC_W6 16'h003F
`define AFIC_W22 16'h0004
`define AFIC_W47 16'h8001
`define AFIC_W49 16'h0F00
`define AFIC_W50 16'h4000
`define AFIC_W51 16'h0200
`define AFIC_W53 16'h0007
`define AFIC_W54 16'h3FFF
`define AFIC_W55 16'h0010
`define AFIC_W56 16'h003F
`define AFIC_W59_RST 16'h0101
`define AFIC_SN_FIRST 8'h0A
`define AFIC_SN_LAST 8'h13
`define AFIC_FW_FIRST 8'h17
`define AFIC_FW_LAST 8'h1A
`define AFIC_MD_FIRST 8'h1B
`define AFIC_MD_LAST 8'h2E

`endif

// [logic/afic_ident.v]
// identify parameter words 0 to 59
`default_nettype none
`include "afic_consts.vh"

module afic_ident #(
    parameter [159:0] SERIAL = {{12{8'h20}}, "00000001"},
    parameter [63:0] FW_REV = "REV00001",
    parameter [319:0] MODEL = {{29{8'h20}}, "GENERIC-SSD"}
) (
    input wire [7:0] idx,
    input wire [31:0] capacity,
    input wire [15:0] multi,
    output reg [15:0] word
);
    wire [7:0] sn_off = `AFIC_SN_LAST - idx;
    wire [7:0] fw_off = `AFIC_FW_LAST - idx;
    wire [7:0] md_off = `AFIC_MD_LAST - idx;
    wire [159:0] sn_sh = SERIAL >> {sn_off, 4'h0};
    wire [63:0] fw_sh = FW_REV >> {fw_off, 4'h0};
    wire [319:0] md_sh = MODEL >> {md_off, 4'h0};

    always @* begin
        word = 16'h0000;
        if (idx >= `AFIC_SN_FIRST && idx <= `AFIC_SN_LAST) begin
            word = sn_sh[15:0];
        end else if (idx >= `AFIC_FW_FIRST && idx <= `AFIC_FW_LAST) begin
            word = fw_sh[15:0];
        end else if (idx >= `AFIC_MD_FIRST && idx <= `AFIC_MD_LAST) begin
            word = md_sh[15:0];
        end else begin
            case (idx)
                8'h00: word = `AFIC_W0;
                8'h01: word = `AFIC_W1;
                8'h02: word = `AFIC_W2;
                8'h03: word = `AFIC_W3;
                8'h05: word = `AFIC_W5;
                8'h06: word = `AFIC_W6;
                8'h16: word = `AFIC_W22;
                8'h2F: word = `AFIC_W47;
                8'h31: word = `AFIC_W49;
                8'h32: word = `AFIC_W50;
                8'h33: word = `AFIC_W51;
                8'h35: word = `AFIC_W53;
                8'h36: word = `AFIC_W54;
                8'h37: word = `AFIC_W55;
                8'h38: word = `AFIC_W56;
                8'h39: word = capacity[15:0];
                8'h3A: word = capacity[31:16];
                8'h3B: word = multi;
                default: word = 16'h0000;
            endcase
        end
    end
endmodule // afic_ident

`default_nettype wire

// [logic/afic_tf_reg.v]
// task-file register pair holding the previous and current byte
`default_nettype none
`include "afic_consts.vh"

module afic_tf_reg (
    input wire clk_sys,
    input wire rst,
    input wire wr,
    input wire [7:0] wdata,
    input wire load,
    input wire [15:0] load_val,
    input wire hob,
    output wire [7:0] rd_byte
);
    reg [7:0] cur;
    reg [7:0] prev;

    // a host write pushes the old byte into the previous slot
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cur <= 8'h00;
            prev <= 8'h00;
        end else if (load) begin
            prev <= load_val[15:8];
            cur <= load_val[7:0];
        end else if (wr) begin
            prev <= cur;
            cur <= wdata;
        end
    end

    assign rd_byte = hob ? prev : cur;
endmodule // afic_tf_reg

`default_nettype wire

// [logic/afic_top.v]
// command block for cache flush, 48-bit cache flush and identify
// Notes on behaviour
// - flush E7h: commit whole write cache, then report ready and seek-complete.
// - flush disabled in configuration: end command with aborted-command error.
// - flush EAh: busy until cache stored or error, then ready and seek-complete.
// - write error on EAh flush: abort, load lba registers with failing sector.
// - later EAh flush resumes at the sector after the failed one.
// - flush writes cached data; an empty cache completes without media writes.
// - identify ECh uses single-sector pio data-in, host reads the block.
// - reserved bits and words of the identify block read as zero.
// - words 10 to 19 carry a right-justified 20-byte ascii serial.
// - words 23 to 26 carry firmware revision, first character in high byte.
// - words 27 to 46 carry the right-justified ascii model string.
// - word 47 is maximum multiple sector count, 8001h.
// - word 49 advertises dma, lba and iordy support.
// - word 53 is 0007h, validity of geometry, transfer-mode and udma words.
// - words 54 to 56 are 3fffh, 0010h and 003fh.
// - words 57 and 58 hold capacity, low half in 57.
// - word 59 follows the multiple setting, default 0101h, host may change.
// - word 51 is 0200h, pio timing mode 2.
// - hob bit of device control selects high or low byte on reads.
//
// The plain strobed port and the register offsets were left to the implementer.
`default_nettype none
`include "afic_consts.vh"

module afic_top (
    input wire clk_sys,
    input wire rst,
    input wire [3:0] addr,
    input wire [15:0] wdata,
    input wire wr,
    input wire rd,
    output reg [15:0] rdata,
    input wire cache_empty,
    input wire wb_done,
    input wire wb_err,
    input wire [47:0] wb_err_lba,
    input wire [31:0] capacity,
    output reg flush_start,
    output reg flush_resume,
    output reg [47:0] flush_from
);
    localparam [2:0] S_IDLE = 3'd0;
    localparam [2:0] S_FLUSH = 3'd1;
    localparam [2:0] S_FLUSH_WAIT = 3'd2;
    localparam [2:0] S_ID_PREP = 3'd3;
    localparam [2:0] S_ID_XFER = 3'd4;

    reg [2:0] state;
    reg [7:0] status;
    reg [7:0] error;
    reg [7:0] device;
    reg [7:0] cfg;
    reg [15:0] multi;
    reg hob;
    reg ext_cmd;
    reg [7:0] word_idx;
    reg resume_valid;
    reg [47:0] resume_lba;
    reg tf_load;
    reg [47:0] tf_load_lba;

    wire busy = status[`AFIC_ST_BSY_BIT];
    // task-file writes are ignored while the busy bit is set, not in the identify data phase
    wire host_wr = wr && !busy;
    wire cmd_wr = host_wr && addr == `AFIC_A_STATUS;
    wire [7:0] opcode = wdata[7:0];
    wire data_rd = rd && addr == `AFIC_A_DATA && state == S_ID_XFER;

    wire [7:0] feat_b;
    wire [7:0] count_b;
    wire [7:0] lo_b;
    wire [7:0] mid_b;
    wire [7:0] hi_b;
    wire [15:0] id_word;

    afic_tf_reg u_feat (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr(host_wr && addr == `AFIC_A_ERR),
        .wdata(wdata[7:0]),
        .load(1'b0),
        .load_val(16'h0000),
        .hob(hob),
        .rd_byte(feat_b)
    );

    afic_tf_reg u_count (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr(host_wr && addr == `AFIC_A_COUNT),
        .wdata(wdata[7:0]),
        .load(1'b0),
        .load_val(16'h0000),
        .hob(hob),
        .rd_byte(count_b)
    );

    // failing sector address is split into current and previous bytes
    afic_tf_reg u_lba_lo (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr(host_wr && addr == `AFIC_A_LBA_LO),
        .wdata(wdata[7:0]),
        .load(tf_load),
        .load_val({tf_load_lba[31:24], tf_load_lba[7:0]}),
        .hob(hob),
        .rd_byte(lo_b)
    );

    afic_tf_reg u_lba_mid (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr(host_wr && addr == `AFIC_A_LBA_MID),
        .wdata(wdata[7:0]),
        .load(tf_load),
        .load_val({tf_load_lba[39:32], tf_load_lba[15:8]}),
        .hob(hob),
        .rd_byte(mid_b)
    );

    afic_tf_reg u_lba_hi (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr(host_wr && addr == `AFIC_A_LBA_HI),
        .wdata(wdata[7:0]),
        .load(tf_load),
        .load_val({tf_load_lba[47:40], tf_load_lba[23:16]}),
        .hob(hob),
        .rd_byte(hi_b)
    );

    afic_ident u_ident (
        .idx(word_idx),
        .capacity(capacity),
        .multi(multi),
        .word(id_word)
    );

    // host-side settings; device control and config stay writable while busy
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hob <= 1'b0;
            cfg <= `AFIC_CFG_RST;
            multi <= `AFIC_W59_RST;
            device <= 8'h00;
        end else if (wr) begin
            case (addr)
                `AFIC_A_CTRL: hob <= wdata[`AFIC_CTRL_HOB];
                `AFIC_A_CONFIG: cfg <= wdata[7:0];
                `AFIC_A_MULTI: multi <= wdata;
                `AFIC_A_DEVICE: begin
                    if (!busy) begin
                        device <= wdata[7:0];
                    end
                end
                default: hob <= hob;
            endcase
        end
    end

    // command sequencer
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= S_IDLE;
            status <= `AFIC_ST_READY;
            error <= 8'h00;
            ext_cmd <= 1'b0;
            word_idx <= 8'h00;
            resume_valid <= 1'b0;
            resume_lba <= 48'h000000000000;
            tf_load <= 1'b0;
            tf_load_lba <= 48'h000000000000;
            flush_start <= 1'b0;
            flush_resume <= 1'b0;
            flush_from <= 48'h000000000000;
        end else begin
            flush_start <= 1'b0;
            tf_load <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (cmd_wr) begin
                        error <= 8'h00;
                        case (opcode)
                            `AFIC_OP_FLUSH, `AFIC_OP_FLUSH_EXT: begin
                                ext_cmd <= opcode == `AFIC_OP_FLUSH_EXT;
                                if (!cfg[`AFIC_CFG_FLUSH_EN]) begin
                                    status <= `AFIC_ST_ABORT;
                                    error <= `AFIC_ERR_ABRT;
                                end else begin
                                    status <= `AFIC_ST_BUSY;
                                    state <= S_FLUSH;
                                end
                            end
                            `AFIC_OP_IDENT: begin
                                status <= `AFIC_ST_BUSY;
                                word_idx <= 8'h00;
                                state <= S_ID_PREP;
                            end
                            // other opcodes belong to other blocks
                            default: status <= status;
                        endcase
                    end
                end
                S_FLUSH: begin
                    if (cache_empty) begin
                        status <= `AFIC_ST_READY;
                        state <= S_IDLE;
                    end else begin
                        flush_start <= 1'b1;
                        flush_resume <= ext_cmd && resume_valid;
                        flush_from <= resume_lba;
                        state <= S_FLUSH_WAIT;
                    end
                end
                S_FLUSH_WAIT: begin
                    // busy holds until the engine reports an outcome
                    if (wb_err) begin
                        status <= `AFIC_ST_ABORT;
                        error <= `AFIC_ERR_ABRT;
                        tf_load <= 1'b1;
                        tf_load_lba <= wb_err_lba;
                        if (ext_cmd) begin
                            resume_valid <= 1'b1;
                            resume_lba <= wb_err_lba + 48'h000000000001;
                        end
                        state <= S_IDLE;
                    end else if (wb_done) begin
                        status <= `AFIC_ST_READY;
                        if (ext_cmd) begin
                            resume_valid <= 1'b0;
                        end
                        state <= S_IDLE;
                    end
                end
                S_ID_PREP: begin
                    status <= `AFIC_ST_DRQ;
                    state <= S_ID_XFER;
                end
                S_ID_XFER: begin
                    if (data_rd) begin
                        word_idx <= word_idx + 8'h01;
                        if (word_idx == `AFIC_ID_LAST) begin
                            status <= `AFIC_ST_READY;
                            state <= S_IDLE;
                        end
                    end
                end
                default: begin
                    state <= S_IDLE;
                    status <= `AFIC_ST_READY;
                end
            endcase
        end
    end

    // read data registered, valid the cycle after the strobe
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            case (addr)
                `AFIC_A_DATA: rdata <= (state == S_ID_XFER) ? id_word : 16'h0000;
                `AFIC_A_ERR: rdata <= {8'h00, error};
                `AFIC_A_COUNT: rdata <= {8'h00, count_b};
                `AFIC_A_LBA_LO: rdata <= {8'h00, lo_b};
                `AFIC_A_LBA_MID: rdata <= {8'h00, mid_b};
                `AFIC_A_LBA_HI: rdata <= {8'h00, hi_b};
                `AFIC_A_DEVICE: rdata <= {8'h00, device};
                `AFIC_A_STATUS: rdata <= {8'h00, status};
                `AFIC_A_CTRL: rdata <= {8'h00, status};
                `AFIC_A_CONFIG: rdata <= {8'h00, cfg};
                `AFIC_A_MULTI: rdata <= multi;
                default: rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

    // features byte is decoded by other command blocks only
    wire unused_ok = &{1'b0, feat_b};
endmodule // afic_top

`default_nettype wire

// [test/afic_engine_model.sv]
// write-back engine model answering flush requests of the command block
`default_nettype none
module afic_engine_model #(
    parameter int DELAY = 12
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic flush_start,
    input wire logic fail_next,
    input wire logic [47:0] fail_lba,
    output var logic wb_done,
    output var logic wb_err,
    output var logic [47:0] wb_err_lba
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            wb_done <= 1'b0;
            wb_err <= 1'b0;
            wb_err_lba <= 48'h0;
        end else begin
            wb_done <= 1'b0;
            wb_err <= 1'b0;
            // address is only valid with the error pulse, so it never holds still
            wb_err_lba <= ~wb_err_lba;
            if (flush_start) begin
                cnt <= DELAY;
            end else if (cnt == 1) begin
                cnt <= 0;
                if (fail_next) begin
                    wb_err <= 1'b1;
                    wb_err_lba <= fail_lba;
                end else begin
                    wb_done <= 1'b1;
                end
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule // afic_engine_model
`default_nettype wire

// [test/afic_top_chk.sv]
// assertion checker on the ports of the command block
`default_nettype none
`include "afic_consts.vh"
module afic_top_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic cache_empty,
    input wire logic wb_done,
    input wire logic wb_err,
    input wire logic [47:0] wb_err_lba,
    input wire logic flush_start,
    input wire logic flush_resume,
    input wire logic [47:0] flush_from
);
    timeunit 1ns;
    timeprecision 1ns;
    logic hob_seen;
    logic err_seen;
    logic [47:0] last_err;
    wire logic is_flush = wr && addr == 4'h7 && (wdata[7:0] == 8'hE7 || wdata[7:0] == 8'hEA);
    wire logic [7:0] lo_exp = hob_seen ? last_err[31:24] : last_err[7:0];
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hob_seen <= 1'b0;
            err_seen <= 1'b0;
            last_err <= 48'h0;
        end else begin
            if (wr && addr == 4'h8) hob_seen <= wdata[7];
            if (wb_err) err_seen <= 1'b1;
            if (wb_err) last_err <= wb_err_lba;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_ident;
        wr && addr == 4'h7 && wdata[7:0] == 8'hEC ##2 rd && addr == 4'h7;
    endsequence
    sequence s_off;
        wr && addr == 4'h9 && !wdata[0] ##1 wr && addr == 4'h7 && wdata[7:0] == 8'hE7 ##1 rd && addr == 4'h7;
    endsequence
    property p_rd_idle; !$past(rd) |-> rdata == 16'h0000; endproperty
    property p_start_pulse; flush_start |=> !flush_start; endproperty
    property p_start_cause; flush_start |-> $past(is_flush, 2) && !$past(cache_empty); endproperty
    property p_resume; flush_start && flush_resume |-> flush_from == last_err + 48'h1; endproperty
    property p_ident_drq; s_ident |=> rdata == 16'h0058; endproperty
    property p_flush_off; s_off |=> rdata == 16'h0051; endproperty
    property p_done; wb_done ##1 rd && addr == 4'h7 |=> rdata == 16'h0050; endproperty
    property p_err_st; wb_err ##1 rd && addr == 4'h7 |=> rdata == 16'h0051; endproperty
    property p_err_code; wb_err ##2 rd && addr == 4'h1 |=> rdata == 16'h0004; endproperty
    property p_err_lba; err_seen && rd && addr == 4'h3 |=> rdata[7:0] == $past(lo_exp); endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
    a_start_cause: assert property (p_start_cause) else $error("start without command or data");
    a_resume: assert property (p_resume) else $error("resume sector wrong");
    a_ident_drq: assert property (p_ident_drq) else $error("identify not ready");
    a_flush_off: assert property (p_flush_off) else $error("disabled flush not aborted");
    a_done: assert property (p_done) else $error("no ready after write-back");
    a_err_st: assert property (p_err_st) else $error("no abort after write error");
    a_err_code: assert property (p_err_code) else $error("error code wrong");
    a_err_lba: assert property (p_err_lba) else $error("failing sector byte wrong");
endmodule // afic_top_chk
`default_nettype wire

// [test/afic_top_tb.sv]
// self-checking bench for the flush and identify command block
`default_nettype none
`include "afic_consts.vh"
module afic_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [159:0] SN = {{12{8'h20}}, "00000001"};
    localparam logic [63:0] FW = "REV00001";
    localparam logic [319:0] MD = {{29{8'h20}}, "GENERIC-SSD"};
    logic clk_sys, rst, wr, rd, cache_empty, fail_next, rd_d;
    logic [3:0] addr;
    logic [15:0] wdata, multi;
    logic [31:0] capacity;
    logic [47:0] fail_lba;
    wire logic [15:0] rdata;
    wire logic wb_done, wb_err, flush_start, flush_resume;
    wire logic [47:0] wb_err_lba, flush_from;
    logic [15:0] exp_rd[$];
    logic [48:0] exp_fs[$];
    int err_total, checked, seed, h, k;
    afic_top uut (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .cache_empty(cache_empty), .wb_done(wb_done), .wb_err(wb_err), .wb_err_lba(wb_err_lba),
        .capacity(capacity), .flush_start(flush_start), .flush_resume(flush_resume), .flush_from(flush_from));
    afic_engine_model eng (.clk_sys(clk_sys), .rst(rst), .flush_start(flush_start), .fail_next(fail_next),
        .fail_lba(fail_lba), .wb_done(wb_done), .wb_err(wb_err), .wb_err_lba(wb_err_lba));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic fail(input string m);
        err_total++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask
    task automatic cmp_rd(input logic [15:0] got, exp);
        checked++;
        if (got !== exp) fail("read data");
    endtask
    task automatic cmp_fs(input logic [48:0] e);
        checked++;
        if (flush_resume !== e[48] || (e[48] && flush_from !== e[47:0])) fail("resume point");
    endtask
    task automatic end_of_test();
        if (err_total == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic bus(input logic w, r, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        exp_rd.push_back(e);
        bus(1'b0, 1'b1, a, 16'h0000);
    endtask
    function automatic logic [15:0] idw(input int n);
        case (n)
            0: return `AFIC_W0;
            1: return `AFIC_W1;
            2: return `AFIC_W2;
            3: return `AFIC_W3;
            5: return `AFIC_W5;
            6: return `AFIC_W6;
            22: return `AFIC_W22;
            47: return 16'h8001;
            49: return `AFIC_W49;
            50: return `AFIC_W50;
            51: return 16'h0200;
            53: return 16'h0007;
            54: return 16'h3FFF;
            55: return 16'h0010;
            56: return 16'h003F;
            57: return capacity[15:0];
            58: return capacity[31:16];
            59: return multi;
            default: begin end
        endcase
        if (n >= 10 && n <= 19) return SN[159 - 16 * (n - 10) -: 16];
        if (n >= 23 && n <= 26) return FW[63 - 16 * (n - 23) -: 16];
        if (n >= 27 && n <= 46) return MD[319 - 16 * (n - 27) -: 16];
        return 16'h0000;
    endfunction
    task automatic ident();
        int n;
        bus(1'b1, 1'b0, 4'h7, 16'h00EC);
        rd_chk(4'h7, 16'h0080);
        rd_chk(4'h7, 16'h0058);
        for (n = 0; n < 256; n++) rd_chk(4'h0, idw(n));
        bus(1'b0, 1'b0, 4'h0, 16'h0000);
        rd_chk(4'h7, 16'h0050);
        bus(1'b0, 1'b0, 4'h0, 16'h0000);
    endtask
    task automatic flush(input logic [7:0] op, input logic empty, bad, input logic [48:0] e);
        int n;
        cache_empty <= empty;
        fail_next <= bad;
        if (!empty) exp_fs.push_back(e);
        bus(1'b1, 1'b0, 4'h7, {8'h00, op});
        rd_chk(4'h7, 16'h0080);
        bus(1'b0, 1'b0, 4'h0, 16'h0000);
        if (empty) begin
            rd_chk(4'h7, 16'h0050);
        end else begin
            // bounded wait: a lost start would otherwise hang here
            for (n = 0; n < 100 && wb_done !== 1'b1 && wb_err !== 1'b1; n++) @(posedge clk_sys);
            if (n == 100) fail("no write-back answer");
            rd_chk(4'h7, bad ? 16'h0051 : 16'h0050);
            if (bad) rd_chk(4'h1, 16'h0004);
        end
        bus(1'b0, 1'b0, 4'h0, 16'h0000);
    endtask
    always @(posedge clk_sys) rd_d <= rd;
    always @(negedge clk_sys) begin
        if (rd_d === 1'b1) begin
            if (exp_rd.size() == 0) fail("unexpected read");
            else cmp_rd(rdata, exp_rd.pop_front());
        end
        if (flush_start === 1'b1) begin
            if (exp_fs.size() == 0) fail("unexpected start");
            else cmp_fs(exp_fs.pop_front());
        end
    end
    initial begin
        #(100 * 20000);
        err_total++;
        end_of_test();
    end
    initial begin
        seed = 32'h163ca108;
        {rst, wr, rd, cache_empty, fail_next, rd_d} = 6'b100100;
        addr = 4'h0;
        wdata = 16'h0000;
        fail_lba = 48'h0;
        capacity = 32'h0;
        multi = 16'h0101;
        err_total = 0;
        checked = 0;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        capacity <= 32'($random(seed));
        fail_lba <= {16'($random(seed)), 32'($random(seed))};
        rd_chk(4'h7, 16'h0050);
        rd_chk(4'h9, 16'h0001);
        rd_chk(4'hA, 16'h0101);
        rd_chk(4'hF, 16'h0000);
        bus(1'b1, 1'b0, 4'h7, 16'h0000);
        rd_chk(4'h7, 16'h0050);
        ident();
        multi = {8'h01, 8'($random(seed))};
        bus(1'b1, 1'b0, 4'hA, multi);
        ident();
        flush(8'hEA, 1'b0, 1'b1, 49'h0);
        for (h = 0; h < 2; h++) begin
            bus(1'b1, 1'b0, 4'h8, h ? 16'h0080 : 16'h0000);
            for (k = 0; k < 3; k++) rd_chk(4'(3 + k), {8'h00, fail_lba[8 * (k + 3 * h) +: 8]});
        end
        flush(8'hEA, 1'b0, 1'b0, {1'b1, fail_lba + 48'h1});
        flush(8'hE7, 1'b0, 1'b0, 49'h0);
        flush(8'hE7, 1'b1, 1'b0, 49'h0);
        flush(8'hEA, 1'b1, 1'b0, 49'h0);
        bus(1'b1, 1'b0, 4'h9, 16'h0000);
        bus(1'b1, 1'b0, 4'h7, 16'h00E7);
        rd_chk(4'h7, 16'h0051);
        rd_chk(4'h1, 16'h0004);
        bus(1'b1, 1'b0, 4'h9, 16'h0001);
        bus(1'b0, 1'b0, 4'h0, 16'h0000);
        repeat (4) @(posedge clk_sys);
        end_of_test();
    end
endmodule // afic_top_tb
bind afic_top afic_top_chk chk (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cache_empty(cache_empty), .wb_done(wb_done), .wb_err(wb_err), .wb_err_lba(wb_err_lba),
    .flush_start(flush_start), .flush_resume(flush_resume), .flush_from(flush_from));
`default_nettype wire
